// [verilog/cmvs_sequencer.sv]
// Purpose: self-test sequencer that steps the datapath through numbered tests
// Assumes: datapath runs one test step per request and answers with pass/fail
// Notes:   the datapath performs the bus and register work; this block orders,
//          judges and reports; the check-flag pin is asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none

module cmvs_sequencer
  import cmvs_pkg::*;
#(
  parameter int DATA_W = CMVS_DATA_W,
  parameter int TEST_W = CMVS_TEST_W
) (
  input  wire logic              CLK,            // 125 MHz processor clock
  input  wire logic              RESET_N,        // async reset, low active
  input  wire logic              SYS_CLEAR,      // control panel clear pulse
  input  wire logic              CHECK_FLAG,     // machine check flag pin
  input  wire logic              RUN_OP,         // run_selftest_op decoded
  input  wire logic              ENTER_CHK_OP,   // enter_check_mode_op decoded
  input  wire logic              LEAVE_CHK_OP,   // leave_check_mode_op decoded
  input  wire logic              STEP_DONE,      // datapath finished a step
  input  wire logic              STEP_FAIL,      // step result mismatch
  input  wire logic              STEP_PARITY,    // parity flagged during step
  output logic                   STEP_REQ,       // start a test step
  output logic [TEST_W-1:0]      STEP_TEST,      // test number to run
  output logic [4:0]             STEP_INDEX,     // bit walk index
  output logic [DATA_W-1:0]      STEP_PATTERN,   // pattern for the step
  output logic                   STEP_EXPECT_PE, // step should see parity error
  output logic [DATA_W-1:0]      STEP_MEM_ADDR,  // memory location for test 12
  output logic                   FETCH_HOLD,     // stall instruction fetch
  output logic                   CLEAR_STATE,    // clear keys and register set
  output logic                   CLEAR_CHECK,    // clear machine check flag
  output logic                   INT_REQ,        // program interrupt pulse
  output logic [DATA_W-1:0]      INT_VECTOR,     // interrupt location
  output logic                   SKIP_NEXT,      // op passed: skip pulse
  output logic                   RETURN_FAIL,    // op failed: return pulse
  output logic [DATA_W-1:0]      RETURN_VALUE,   // failed test number
  output logic [TEST_W-1:0]      ADDR_LIGHTS,    // address indicator value
  output logic                   CHECK_MODE      // check-triggered start enabled
);

  initial begin
    if (DATA_W != 16 || TEST_W < 4) begin
      $error("cmvs_sequencer: unsupported width");
    end
  end

  cmvs_state_type     state;
  cmvs_state_type     next_state;
  cmvs_src_type       src;
  logic [TEST_W-1:0]  test_num;
  logic [4:0]         walk;
  logic               pass_bad;
  logic               parity_seen;
  logic               check_mode;
  logic               clear_run_done;
  logic [2:0]         chk_sync;
  logic               chk_level;
  logic               chk_prev;
  logic               any_bad_hold;
  logic               step_fail_q;
  logic               step_parity_q;

  // three-stage sync; a change counts only when the last two agree
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chk_sync <= 3'h0;
    end else begin
      chk_sync <= {chk_sync[1:0], CHECK_FLAG};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chk_level <= 1'b0;
      chk_prev  <= 1'b0;
    end else begin
      if (chk_sync[2] == chk_sync[1]) begin
        chk_level <= chk_sync[2];
      end
      chk_prev <= chk_level;
    end
  end

  function automatic logic walk_test(input logic [TEST_W-1:0] t);
    walk_test = (t == TEST_W'(4'h9)) || (t == TEST_W'(4'hA));
  endfunction : walk_test

  function automatic logic parity_test(input logic [TEST_W-1:0] t);
    parity_test = (t == TEST_W'(4'h4)) || (t == TEST_W'(4'h5)) ||
                  (t == TEST_W'(4'h6));
  endfunction : parity_test

  wire chk_rise     = chk_level & ~chk_prev;
  wire check_start  = chk_rise & check_mode & clear_run_done;
  wire idle         = (state == CMVS_IDLE);
  wire start_any    = idle & (SYS_CLEAR | check_start | RUN_OP);
  wire is_walk      = walk_test(test_num);
  wire walk_more    = is_walk & (walk != CMVS_WALK_LAST);
  // a provoked parity error that goes unseen is a failure, as is one unasked
  wire pe_expected  = parity_test(test_num);
  // judged from the copies taken in the done cycle, never the live lines
  wire step_bad     = step_fail_q | (step_parity_q != pe_expected);
  wire last_test    = (test_num == TEST_W'(CMVS_LAST_TEST));
  wire run_bad      = pass_bad | step_bad;
  // test thirteen reports parity seen in tests seven through twelve
  wire final_bad    = last_test & parity_seen;
  wire any_bad      = step_bad | final_bad;
  wire stop_on_err  = (src != CMVS_SRC_CLEAR);

  always_comb begin
    next_state = state;
    unique case (state)
      CMVS_IDLE:   if (start_any) next_state = CMVS_ISSUE;
      CMVS_ISSUE:  next_state = CMVS_WAIT;
      CMVS_WAIT:   if (STEP_DONE) next_state = CMVS_EVAL;
      CMVS_EVAL: begin
        if (any_bad && stop_on_err) begin
          next_state = CMVS_FINISH;
        end else if (walk_more || !last_test) begin
          next_state = CMVS_ISSUE;
        end else if (run_bad || final_bad) begin
          next_state = CMVS_ISSUE;
        end else begin
          next_state = CMVS_FINISH;
        end
      end
      CMVS_FINISH: next_state = CMVS_HOLD;
      CMVS_HOLD:   next_state = CMVS_IDLE;
      default:     next_state = CMVS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= CMVS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      src <= CMVS_SRC_NONE;
    end else if (start_any) begin
      if (SYS_CLEAR) begin
        src <= CMVS_SRC_CLEAR;
      end else if (check_start) begin
        src <= CMVS_SRC_CHECK;
      end else begin
        src <= CMVS_SRC_OP;
      end
    end
  end

  // test number and bit walk step; tests 0..13 octal in order
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      test_num <= '0;
      walk     <= '0;
    end else if (start_any) begin
      test_num <= TEST_W'(CMVS_FIRST_TEST);
      walk     <= '0;
    end else if (state == CMVS_EVAL && next_state == CMVS_ISSUE) begin
      if (walk_more) begin
        walk <= walk + 5'h1;
      end else if (last_test) begin
        // recycle: keep the failing number on the lights while restarting
        test_num <= TEST_W'(CMVS_FIRST_TEST);
        walk     <= '0;
      end else begin
        test_num <= test_num + TEST_W'(1);
        walk     <= '0;
      end
    end
  end

  // the datapath only promises its result lines in the done cycle, so they
  // are captured there and judged from the copies one state later
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      step_fail_q   <= 1'b0;
      step_parity_q <= 1'b0;
    end else if (state == CMVS_WAIT && STEP_DONE) begin
      step_fail_q   <= STEP_FAIL;
      step_parity_q <= STEP_PARITY;
    end
  end

  // judging strobes; the end of a pass wipes the slate before any recycle
  wire eval     = (state == CMVS_EVAL);
  wire pass_end = eval & last_test & ~walk_more;

  // failure bookkeeping within one pass
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pass_bad    <= 1'b0;
      parity_seen <= 1'b0;
    end else if (start_any || pass_end) begin
      pass_bad    <= 1'b0;
      parity_seen <= 1'b0;
    end else if (eval) begin
      if (step_bad) begin
        pass_bad <= 1'b1;
      end
      if (step_parity_q && test_num >= TEST_W'(4'h7)) begin
        parity_seen <= 1'b1;
      end
    end
  end

  // lights keep the last failing test through a recycle and into idle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ADDR_LIGHTS <= '0;
    end else if (eval && any_bad) begin
      ADDR_LIGHTS <= test_num;
    end
  end

  // check mode; a clear-started run leaves the machine in normal mode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      check_mode     <= 1'b0;
      clear_run_done <= 1'b0;
    end else begin
      if (SYS_CLEAR && idle) begin
        check_mode     <= 1'b0;
        clear_run_done <= 1'b0;
      end else if (state == CMVS_FINISH && src == CMVS_SRC_CLEAR) begin
        clear_run_done <= 1'b1;
      end
      if (ENTER_CHK_OP) begin
        check_mode <= 1'b1;
      end else if (LEAVE_CHK_OP) begin
        check_mode <= 1'b0;
      end
    end
  end

  // exit decode per start source; only an op run reports back to the program
  wire from_check = (src == CMVS_SRC_CHECK);
  wire from_op    = (src == CMVS_SRC_OP);
  wire finish     = (state == CMVS_FINISH);
  wire fin_clean  = finish & ~any_bad_hold;
  wire fin_bad    = finish & any_bad_hold;

  // verdict of the last judged step, read while finishing
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      any_bad_hold <= 1'b0;
    end else if (eval) begin
      any_bad_hold <= any_bad;
    end
  end

  // result outputs from flip-flops; one-cycle pulses except RETURN_VALUE, which holds
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CLEAR_STATE  <= 1'b0;
      CLEAR_CHECK  <= 1'b0;
      INT_REQ      <= 1'b0;
      SKIP_NEXT    <= 1'b0;
      RETURN_FAIL  <= 1'b0;
      RETURN_VALUE <= '0;
    end else begin
      CLEAR_STATE  <= fin_clean & ~from_op;
      INT_REQ      <= fin_clean & from_check;
      // a check-started run always drops the flag, clean or not
      CLEAR_CHECK  <= finish & from_check;
      SKIP_NEXT    <= fin_clean & from_op;
      RETURN_FAIL  <= fin_bad & from_op;
      if (fin_bad) begin
        RETURN_VALUE <= DATA_W'(ADDR_LIGHTS);
      end
    end
  end

  // step request data; per-test pattern choice
  wire [DATA_W-1:0] walk_bit = DATA_W'(16'h0001) << walk[3:0];
  wire [DATA_W-1:0] walk_pat = walk[4] ? ~walk_bit : walk_bit;
  wire [DATA_W-1:0] pat_sel =
      (test_num == TEST_W'(4'h3)) ? CMVS_LOW_BYTE :
      (test_num == TEST_W'(4'h7)) ? CMVS_ONES :
      (test_num == TEST_W'(4'h8)) ? (walk[0] ? CMVS_PAT_5 : CMVS_PAT_A) :
      is_walk                     ? walk_pat :
      CMVS_ZERO;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STEP_REQ       <= 1'b0;
      STEP_TEST      <= '0;
      STEP_INDEX     <= '0;
      STEP_PATTERN   <= '0;
      STEP_EXPECT_PE <= 1'b0;
      STEP_MEM_ADDR  <= '0;
    end else begin
      STEP_REQ <= (state == CMVS_ISSUE);
      if (state == CMVS_ISSUE) begin
        STEP_TEST      <= test_num;
        STEP_INDEX     <= walk;
        STEP_PATTERN   <= pat_sel;
        STEP_EXPECT_PE <= pe_expected;
        STEP_MEM_ADDR  <= CMVS_MEM_LOC;
      end
    end
  end

  // hold off fetch while running and while a check error persists
  // a program that must run on with a stuck flag has to leave check mode
  assign FETCH_HOLD = ~idle | (check_mode & chk_level & clear_run_done);
  assign INT_VECTOR = CMVS_INT_VECTOR;
  assign CHECK_MODE = check_mode;

endmodule : cmvs_sequencer
`default_nettype wire

// [inc/cmvs_pkg.sv]
// Purpose: constants and types for the self-test sequencer
// Assumes: 16-bit datapath, one clock
// Notes:   test numbers are the octal figures printed for each test
package cmvs_pkg;
  localparam int          CMVS_DATA_W     = 16;
  localparam int          CMVS_TEST_W     = 4;
  localparam logic [3:0]  CMVS_FIRST_TEST = 4'h0;
  localparam logic [3:0]  CMVS_LAST_TEST  = 4'hB;  // octal 13
  localparam logic [15:0] CMVS_INT_VECTOR = 16'h0038; // octal 70
  localparam logic [15:0] CMVS_MEM_LOC    = 16'h0005;
  localparam logic [15:0] CMVS_ONES       = 16'hFFFF;
  localparam logic [15:0] CMVS_ZERO       = 16'h0000;
  localparam logic [15:0] CMVS_LOW_BYTE   = 16'h00FF;
  localparam logic [15:0] CMVS_PAT_A      = 16'hAAAA;
  localparam logic [15:0] CMVS_PAT_5      = 16'h5555;
  localparam int          CMVS_WALK_W     = 5;     // 16 ones + 16 zeros steps
  localparam logic [4:0]  CMVS_WALK_LAST  = 5'h1F;

  typedef enum logic [1:0] {
    CMVS_SRC_NONE  = 2'h0,
    CMVS_SRC_CLEAR = 2'h1,
    CMVS_SRC_CHECK = 2'h2,
    CMVS_SRC_OP    = 2'h3
  } cmvs_src_type;

  typedef enum logic [5:0] {
    CMVS_IDLE   = 6'b000001,
    CMVS_ISSUE  = 6'b000010,
    CMVS_WAIT   = 6'b000100,
    CMVS_EVAL   = 6'b001000,
    CMVS_FINISH = 6'b010000,
    CMVS_HOLD   = 6'b100000
  } cmvs_state_type;
endpackage : cmvs_pkg

// [tb/cmvs_sequencer_props.sv]
// Purpose: port assertions for the self-test sequencer
// Assumes: one clock, async active-low reset
// Notes:   bound into every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module cmvs_sequencer_props
  import cmvs_pkg::*;
#(
  parameter int DATA_W = CMVS_DATA_W,
  parameter int TEST_W = CMVS_TEST_W
) (
  input wire logic              CLK,            // clock
  input wire logic              RESET_N,        // reset
  input wire logic              SYS_CLEAR,      // clear start
  input wire logic              RUN_OP,         // op start
  input wire logic              ENTER_CHK_OP,   // mode on
  input wire logic              LEAVE_CHK_OP,   // mode off
  input wire logic              STEP_DONE,      // step end
  input wire logic              STEP_REQ,       // step start
  input wire logic [TEST_W-1:0] STEP_TEST,      // test number
  input wire logic              STEP_EXPECT_PE, // parity due
  input wire logic [DATA_W-1:0] STEP_MEM_ADDR,  // location
  input wire logic              FETCH_HOLD,     // stall
  input wire logic              CLEAR_STATE,    // clear
  input wire logic              CLEAR_CHECK,    // flag clear
  input wire logic              INT_REQ,        // interrupt
  input wire logic              SKIP_NEXT,      // skip
  input wire logic              RETURN_FAIL,    // return
  input wire logic [DATA_W-1:0] RETURN_VALUE,   // failed test
  input wire logic [TEST_W-1:0] ADDR_LIGHTS,    // lights
  input wire logic              CHECK_MODE      // mode
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // starts are checked only when fetch is not held; an idle block also takes one under a check hold
  wire idle_start = (RUN_OP || SYS_CLEAR) && !FETCH_HOLD;
  start_first_a: assert property (idle_start |-> ##2 STEP_REQ && STEP_TEST == 4'h0)
    else $error("start did not issue test zero");
  req_pulse_a: assert property (STEP_REQ |=> !STEP_REQ)
    else $error("step request longer than one cycle");
  hold_step_a: assert property (STEP_REQ |-> FETCH_HOLD)
    else $error("fetch not held during a step");
  step_next_a: assert property (STEP_DONE && FETCH_HOLD |-> ##3
    (STEP_REQ || CLEAR_STATE || CLEAR_CHECK || SKIP_NEXT || RETURN_FAIL))
    else $error("no follow-up after a step");
  int_clear_a: assert property (INT_REQ |-> CLEAR_STATE && CLEAR_CHECK)
    else $error("interrupt without clears");
  ret_value_a: assert property (RETURN_FAIL |-> !SKIP_NEXT &&
    RETURN_VALUE == {{(DATA_W-TEST_W){1'b0}}, ADDR_LIGHTS})
    else $error("return value differs from lights");
  mode_set_a: assert property (ENTER_CHK_OP |=> CHECK_MODE)
    else $error("check mode not entered");
  mode_clr_a: assert property ((LEAVE_CHK_OP || SYS_CLEAR) && !ENTER_CHK_OP
    |=> !CHECK_MODE)
    else $error("check mode not left");
  pe_expect_a: assert property (STEP_REQ |->
    STEP_EXPECT_PE == (STEP_TEST inside {4'h4, 4'h5, 4'h6}))
    else $error("parity expectation wrong");
  mem_loc_a: assert property (STEP_REQ && STEP_TEST == 4'hA |-> STEP_MEM_ADDR == 16'h0005)
    else $error("memory test location wrong");
endmodule : cmvs_sequencer_props
bind cmvs_sequencer cmvs_sequencer_props #(.DATA_W(DATA_W), .TEST_W(TEST_W)) cmvs_sequencer_props_i (
  .CLK(CLK), .RESET_N(RESET_N), .SYS_CLEAR(SYS_CLEAR), .RUN_OP(RUN_OP),
  .ENTER_CHK_OP(ENTER_CHK_OP), .LEAVE_CHK_OP(LEAVE_CHK_OP), .STEP_DONE(STEP_DONE),
  .STEP_REQ(STEP_REQ), .STEP_TEST(STEP_TEST), .STEP_EXPECT_PE(STEP_EXPECT_PE),
  .STEP_MEM_ADDR(STEP_MEM_ADDR), .FETCH_HOLD(FETCH_HOLD), .CLEAR_STATE(CLEAR_STATE),
  .CLEAR_CHECK(CLEAR_CHECK), .INT_REQ(INT_REQ), .SKIP_NEXT(SKIP_NEXT),
  .RETURN_FAIL(RETURN_FAIL), .RETURN_VALUE(RETURN_VALUE), .ADDR_LIGHTS(ADDR_LIGHTS),
  .CHECK_MODE(CHECK_MODE));
`default_nettype wire

// [tb/cmvs_datapath_model.sv]
// Purpose: datapath stand-in answering test steps
// Assumes: one step in flight at a time
// Notes:   result lines carry junk outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module cmvs_datapath_model (
  input wire logic       clk,         // clock
  input wire logic       reset_n,     // reset
  input wire logic       step_req,    // step start
  input wire logic [3:0] step_test,   // test number
  input wire logic       step_pe,     // parity due
  input wire logic       slow,        // long answers
  input wire logic [3:0] bad_test,    // test made to fail
  output logic           step_done,   // step end
  output logic           step_fail,   // mismatch
  output logic           step_parity  // parity seen
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic       toggle;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {wait_cnt, busy, toggle, step_done, step_fail, step_parity} <= '0;
    end else begin
      toggle <= !toggle;
      step_done <= 1'b0;
      step_fail <= toggle;
      step_parity <= !toggle;
      if (step_req) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 4'h9 : 4'h0;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        step_done <= 1'b1;
        step_fail <= (step_test == bad_test);
        step_parity <= step_pe;
      end
    end
  end
endmodule : cmvs_datapath_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the self-test sequencer
// Assumes: datapath model answers every step
// Notes:   a clean pass is 74 steps because of the two bit walks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, check_flag = 1'b0, slow = 1'b0;
  logic [3:0] cmd = 4'h0, bad = 4'hF, last = 4'h0;
  int fails = 0, check_count = 0, steps = 0, cnt[5];
  wire step_req, step_done, step_fail, step_parity, step_pe, fetch_hold, clear_state;
  wire clear_check, int_req, skip_next, return_fail, check_mode;
  wire [3:0] step_test, addr_lights;
  wire [4:0] step_index;
  wire [15:0] step_pattern, mem_addr, int_vector, return_value;
  always #4 clk = !clk;
  cmvs_sequencer cmvs_sequencer_i (.CLK(clk), .RESET_N(reset_n), .SYS_CLEAR(cmd[0]),
    .RUN_OP(cmd[1]), .ENTER_CHK_OP(cmd[2]), .LEAVE_CHK_OP(cmd[3]), .CHECK_FLAG(check_flag),
    .STEP_DONE(step_done), .STEP_FAIL(step_fail), .STEP_PARITY(step_parity),
    .STEP_REQ(step_req), .STEP_TEST(step_test), .STEP_INDEX(step_index),
    .STEP_PATTERN(step_pattern), .STEP_EXPECT_PE(step_pe), .STEP_MEM_ADDR(mem_addr),
    .FETCH_HOLD(fetch_hold), .CLEAR_STATE(clear_state), .CLEAR_CHECK(clear_check),
    .INT_REQ(int_req), .INT_VECTOR(int_vector), .SKIP_NEXT(skip_next),
    .RETURN_FAIL(return_fail), .RETURN_VALUE(return_value), .ADDR_LIGHTS(addr_lights),
    .CHECK_MODE(check_mode));
  cmvs_datapath_model cmvs_datapath_model_i (.clk(clk), .reset_n(reset_n),
    .step_req(step_req), .step_test(step_test), .step_pe(step_pe), .slow(slow),
    .bad_test(bad), .step_done(step_done), .step_fail(step_fail), .step_parity(step_parity));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(logic [15:0] got, logic [15:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp
  always @(negedge clk) begin
    cnt[0] += clear_state;
    cnt[1] += int_req;
    cnt[2] += clear_check;
    cnt[3] += skip_next;
    cnt[4] += return_fail;
    if (step_req === 1'b1) begin
      steps++;
      cmp(step_test == last || step_test == last + 4'h1 || step_test == 4'h0, 1, "order");
      last = step_test;
      if (step_test == 4'h9 || step_test == 4'hA)
        cmp(step_pattern ^ {16{step_index[4]}}, 16'h1 << step_index[3:0], "walk");
      if (step_test < 4'h3) cmp(step_pattern, 16'h0000, "zero pattern");
      if (step_test == 4'h3) cmp(step_pattern, 16'h00FF, "low byte");
      if (step_test == 4'h7) cmp(step_pattern, 16'hFFFF, "minus one");
      if (step_test == 4'h8) cmp(step_pattern, 16'hAAAA, "set pattern");
    end
  end
  task automatic start(int b);
    cnt = '{5{0}};
    steps = 0;
    @(posedge clk) cmd <= 4'h1 << b;
    @(posedge clk) cmd <= 4'h0;
  endtask : start
  // bounded wait for fetch hold to drop after a run
  task automatic wait_done();
    int i;
    for (i = 0; i < 4000 && !(i > 4 && fetch_hold === 1'b0); i++) @(negedge clk);
    cmp(i < 4000, 1, "run hung");
  endtask : wait_done
  task automatic s_clear_clean();
    start(0);
    wait_done();
    cmp(steps, 74, "clear steps");
    cmp({cnt[0][7:0], cnt[1][7:0]}, 16'h0100, "clear exit");
  endtask : s_clear_clean
  task automatic s_op_pass();
    slow <= 1'b1;
    start(1);
    wait_done();
    slow <= 1'b0;
    cmp({cnt[3][3:0], cnt[4][3:0], cnt[1][3:0]}, 16'h0100, "op skip");
  endtask : s_op_pass
  task automatic s_op_fail();
    bad <= 4'h5;
    start(1);
    wait_done();
    cmp(steps, 6, "stop at first error");
    cmp({cnt[3][7:0], cnt[4][7:0]}, 16'h0001, "op return");
    cmp(return_value, 16'h0005, "return number");
    cmp(addr_lights, 4'h5, "lights");
    bad <= 4'hF;
  endtask : s_op_fail
  task automatic s_check_on();
    int i;
    start(2);
    check_flag <= 1'b1;
    @(negedge clk);
    cmp(check_mode, 1, "mode on");
    repeat (8) @(negedge clk);
    cmp(fetch_hold, 1, "hold on error");
    for (i = 0; i < 2000 && cnt[2] == 0; i++) @(negedge clk);
    @(posedge clk) check_flag <= 1'b0;
    wait_done();
    cmp({cnt[0][7:0], cnt[1][7:0]}, 16'h0101, "transient exit");
    cmp(int_vector, 16'h0038, "vector");
  endtask : s_check_on
  task automatic s_check_off();
    start(3);
    check_flag <= 1'b1;
    @(negedge clk);
    cmp(check_mode, 0, "mode off");
    repeat (20) @(negedge clk);
    cmp({fetch_hold, steps[7:0]}, 0, "flag ignored");
    @(posedge clk) check_flag <= 1'b0;
  endtask : s_check_off
  task automatic s_solid();
    bad <= 4'h3;
    start(0);
    repeat (1000) @(negedge clk);
    cmp({fetch_hold, addr_lights}, 5'h13, "recycling");
    cmp(cnt[0], 0, "no exit on fault");
    bad <= 4'hF;
    wait_done();
    cmp(cnt[0], 1, "exit when clean");
    cmp(check_mode, 0, "normal mode after clear");
  endtask : s_solid
  initial begin
    #160000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    s_clear_clean();
    s_op_pass();
    s_op_fail();
    s_check_on();
    s_check_off();
    s_solid();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
